// ---- verilog/cia_pkg.sv ----
// shared types, constants and helpers of the interconnect fabric
package cia_pkg;

   // bus widths
   localparam int CIA_AW = 32;
   localparam int CIA_DW = 32;
   localparam int CIA_BEW = CIA_DW / 8;
   // byte address to word address shift
   localparam int CIA_WORD_LSB = 2;
   // width of wait counters and of the window size field
   localparam int CIA_CNT_W = 4;
   localparam int CIA_SPAN_W = 6;

   typedef logic [CIA_CNT_W-1:0] cia_cnt_t;

   localparam cia_cnt_t CIA_CNT_ZERO = 4'h0;
   localparam cia_cnt_t CIA_CNT_ONE = 4'h1;

   // request from one master
   typedef struct packed {
      logic [CIA_AW-1:0] addr;
      logic rd;
      logic wr;
      logic [CIA_DW-1:0] wdata;
      logic [CIA_BEW-1:0] ben;
   } cia_mreq_s;

   // answer to one master
   typedef struct packed {
      logic [CIA_DW-1:0] rdata;
      logic waitreq;
      logic err;
   } cia_mrsp_s;

   // request to one slave
   typedef struct packed {
      logic sel;
      logic [CIA_AW-1:0] addr;
      logic rd;
      logic wr;
      logic [CIA_DW-1:0] wdata;
      logic [CIA_BEW-1:0] ben;
   } cia_sreq_s;

   // answer from one slave
   typedef struct packed {
      logic [CIA_DW-1:0] rdata;
      logic waitreq;
   } cia_srsp_s;

   // declared placement and timing of one slave
   typedef struct packed {
      logic [CIA_AW-1:0] base;
      logic [CIA_SPAN_W-1:0] span;
      cia_cnt_t setup;
      cia_cnt_t wait_cyc;
      cia_cnt_t hold;
      logic use_wreq;
   } cia_scfg_s;

   // default map: a plain memory and a slow peripheral
   localparam cia_scfg_s CIA_SCFG_S0 = '{base: 32'h0000_0000, span: 6'h10,
      setup: 4'h0, wait_cyc: 4'h0, hold: 4'h0, use_wreq: 1'b0};
   localparam cia_scfg_s CIA_SCFG_S1 = '{base: 32'h0001_0000, span: 6'h0c,
      setup: 4'h1, wait_cyc: 4'h2, hold: 4'h1, use_wreq: 1'b1};

   // wait-state sequencer states
   typedef enum logic [2:0] {
      CIA_IDLE = 3'b000,
      CIA_SETUP = 3'b001,
      CIA_STROBE = 3'b010,
      CIA_HOLD = 3'b011,
      CIA_DONE = 3'b100
   } cia_wst_e;

   // byte mask of a slave window
   function automatic logic [CIA_AW-1:0] cia_mask(input cia_scfg_s cfg);
      cia_mask = (CIA_AW'(1) << cfg.span) - CIA_AW'(1);
   endfunction

   // address falls into the slave window
   function automatic logic cia_hit(input logic [CIA_AW-1:0] addr, input cia_scfg_s cfg);
      cia_hit = ((addr & ~cia_mask(cfg)) == (cfg.base & ~cia_mask(cfg)));
   endfunction

   // word offset inside the slave, upper bits zero
   function automatic logic [CIA_AW-1:0] cia_saddr(input logic [CIA_AW-1:0] addr, input cia_scfg_s cfg);
      cia_saddr = (addr & cia_mask(cfg)) >> CIA_WORD_LSB;
   endfunction

endpackage

// ---- verilog/cia_wait_fsm.sv ----
// wait-state sequencer for one slave port
`timescale 1ns/1ns
module cia_wait_fsm import cia_pkg::*; #(
   parameter cia_scfg_s SCFG = CIA_SCFG_S0
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // fabric side
   input wire logic start,
   input wire logic is_rd,
   output logic done,
   output logic [CIA_DW-1:0] rdata,
   // slave side
   input wire logic slv_wreq,
   input wire logic [CIA_DW-1:0] slv_rdata,
   output logic strobe_rd,
   output logic strobe_wr
);

   typedef struct packed {
      cia_wst_e st;
      cia_cnt_t cnt;
      logic rd;
      logic [CIA_DW-1:0] rdata;
   } cia_wfsm_s;

   cia_wfsm_s st_reg;
   cia_wfsm_s st_next;
   logic slv_ready;

   // slave may finish: fixed count run out and, if used, its stall dropped
   assign slv_ready = (st_reg.cnt == CIA_CNT_ZERO) && !(SCFG.use_wreq && slv_wreq);

   // strobes only in the strobe phase, done only in the done phase
   assign strobe_rd = (st_reg.st == CIA_STROBE) && st_reg.rd;
   assign strobe_wr = (st_reg.st == CIA_STROBE) && !st_reg.rd;
   assign done = (st_reg.st == CIA_DONE);
   assign rdata = st_reg.rdata;

   // next-state logic
   always_comb begin
      st_next = st_reg;
      case (st_reg.st)
         CIA_IDLE: begin
            if (start) begin
               st_next.rd = is_rd;
               if (SCFG.setup != CIA_CNT_ZERO) begin
                  st_next.st = CIA_SETUP;
                  st_next.cnt = SCFG.setup - CIA_CNT_ONE;
               end else begin
                  st_next.st = CIA_STROBE;
                  st_next.cnt = SCFG.wait_cyc;
               end
            end
         end
         CIA_SETUP: begin
            if (st_reg.cnt == CIA_CNT_ZERO) begin
               st_next.st = CIA_STROBE;
               st_next.cnt = SCFG.wait_cyc;
            end else begin
               st_next.cnt = st_reg.cnt - CIA_CNT_ONE;
            end
         end
         CIA_STROBE: begin
            if (slv_ready) begin
               st_next.rdata = st_reg.rd ? slv_rdata : st_reg.rdata;
               if (SCFG.hold != CIA_CNT_ZERO) begin
                  st_next.st = CIA_HOLD;
                  st_next.cnt = SCFG.hold - CIA_CNT_ONE;
               end else begin
                  st_next.st = CIA_DONE;
               end
            end else if (st_reg.cnt != CIA_CNT_ZERO) begin
               st_next.cnt = st_reg.cnt - CIA_CNT_ONE;
            end
         end
         CIA_HOLD: begin
            if (st_reg.cnt == CIA_CNT_ZERO) begin
               st_next.st = CIA_DONE;
            end else begin
               st_next.cnt = st_reg.cnt - CIA_CNT_ONE;
            end
         end
         CIA_DONE: begin
            st_next.st = CIA_IDLE;
         end
         default: begin
            st_next.st = CIA_IDLE;
         end
      endcase
   end

   // state register
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         st_reg <= '{st: CIA_IDLE, cnt: CIA_CNT_ZERO, rd: 1'b0, rdata: '0};
      end else begin
         st_reg <= st_next;
      end
   end

endmodule // cia_wait_fsm

// ---- verilog/cia_fabric.sv ----
// partial-crossbar interconnect between memory-mapped masters and slaves
`timescale 1ns/1ns

// Operation
// - per-slave select asserted on window hit
// - slaves never decode, select does it
// - slave gets word offset, needed bits only
// - one address decoder per master
// - each slave window has own width
// - window placed by base parameter
// - granted master write data to slave
// - selected slave read data to requester
// - one read multiplexer per master
// - wait states add whole cycles
// - wait on every mapped access until the slave is done
// - setup and hold cycles around strobes
// - small state machine sequences the strobes
// - stall master until arbitration grants
// - distinct pairs transfer concurrently
// - synchronous logic, no tristate, no sharing
// - paths registered, sequenced or wired
// - adapt optional slave stall signal
// - wait behaviour from slave timing parameters
module cia_fabric import cia_pkg::*; #(
   parameter int N_MST = 2,
   parameter int N_SLV = 2,
   parameter cia_scfg_s [N_SLV-1:0] SLV_CFG = {CIA_SCFG_S1, CIA_SCFG_S0}
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // master ports
   input wire cia_mreq_s [N_MST-1:0] m_req,
   output cia_mrsp_s [N_MST-1:0] m_rsp,
   // slave ports
   output cia_sreq_s [N_SLV-1:0] s_req,
   input wire cia_srsp_s [N_SLV-1:0] s_rsp
);

   localparam int MIW = (N_MST > 1) ? $clog2(N_MST) : 1;
   localparam int SIW = (N_SLV > 1) ? $clog2(N_SLV) : 1;

   // ownership of each slave
   typedef struct packed {
      logic [N_SLV-1:0] own_vld;
      logic [N_SLV-1:0][MIW-1:0] own_idx;
      logic [N_SLV-1:0][MIW-1:0] last_idx;
   } cia_arb_s;

   cia_arb_s arb_reg;
   cia_arb_s arb_next;

   // decoder results per master
   logic [N_MST-1:0] m_active;
   logic [N_MST-1:0] m_mapped;
   logic [N_MST-1:0][SIW-1:0] m_tgt;

   // sequencer signals per slave
   logic [N_SLV-1:0] s_done;
   logic [N_SLV-1:0] s_strobe_rd;
   logic [N_SLV-1:0] s_strobe_wr;
   logic [N_SLV-1:0][CIA_DW-1:0] s_rdata;
   logic [N_SLV-1:0][N_MST-1:0] s_want;

   // ----------------------------------------------------------------
   // address decoding, one instance per master
   // ----------------------------------------------------------------
   for (genvar gm = 0; gm < N_MST; gm++) begin : g_dec

      // a read or a write is pending
      assign m_active[gm] = m_req[gm].rd || m_req[gm].wr;

      always_comb begin
         m_mapped[gm] = 1'b0;
         m_tgt[gm] = '0;
         // lowest slave index wins on overlapping windows
         for (int s = N_SLV - 1; s >= 0; s--) begin
            if (cia_hit(m_req[gm].addr, SLV_CFG[s])) begin
               m_mapped[gm] = 1'b1;
               m_tgt[gm] = SIW'(s);
            end
         end
      end

   end

   // which masters want which slave
   always_comb begin
      for (int s = 0; s < N_SLV; s++) begin
         for (int m = 0; m < N_MST; m++) begin
            s_want[s][m] = m_active[m] && m_mapped[m] && (m_tgt[m] == SIW'(s));
         end
      end
   end

   // ----------------------------------------------------------------
   // ownership of slaves: round robin from the last owner
   // ----------------------------------------------------------------
   always_comb begin
      int idx;
      logic found;
      idx = 0;
      found = 1'b0;
      arb_next = arb_reg;
      for (int s = 0; s < N_SLV; s++) begin
         found = 1'b0;
         if (arb_reg.own_vld[s]) begin
            // release when the slave transfer is finished
            if (s_done[s]) begin
               arb_next.own_vld[s] = 1'b0;
            end
         end else begin
            for (int k = 1; k <= N_MST; k++) begin
               idx = (int'(arb_reg.last_idx[s]) + k) % N_MST;
               if (!found && s_want[s][idx]) begin
                  found = 1'b1;
                  arb_next.own_vld[s] = 1'b1;
                  arb_next.own_idx[s] = MIW'(idx);
                  arb_next.last_idx[s] = MIW'(idx);
               end
            end
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         arb_reg <= '0;
      end else begin
         arb_reg <= arb_next;
      end
   end

   // ----------------------------------------------------------------
   // slave side: select, address, write data and strobes
   // ----------------------------------------------------------------
   // independent slave paths
   for (genvar gs = 0; gs < N_SLV; gs++) begin : g_slv

      cia_mreq_s own_req;

      // request of the current owner
      // relies on held request
      assign own_req = m_req[arb_reg.own_idx[gs]];

      cia_wait_fsm #(
         .SCFG(SLV_CFG[gs])
      ) u_wait (
         .clk_sys(clk_sys),
         .rst_b(rst_b),
         .start(arb_reg.own_vld[gs] && !s_done[gs]),
         .is_rd(own_req.rd),
         .done(s_done[gs]),
         .rdata(s_rdata[gs]),
         .slv_wreq(s_rsp[gs].waitreq),
         .slv_rdata(s_rsp[gs].rdata),
         .strobe_rd(s_strobe_rd[gs]),
         .strobe_wr(s_strobe_wr[gs])
      );

      // slave port drive
      always_comb begin
         s_req[gs] = '0;
         if (arb_reg.own_vld[gs]) begin
            s_req[gs].sel = 1'b1;
            s_req[gs].addr = cia_saddr(own_req.addr, SLV_CFG[gs]);
            s_req[gs].wdata = own_req.wdata;
            s_req[gs].ben = own_req.ben;
            s_req[gs].rd = s_strobe_rd[gs];
            s_req[gs].wr = s_strobe_wr[gs];
         end
      end

   end

   // ----------------------------------------------------------------
   // master side: stall and read data, one mux per master
   // ----------------------------------------------------------------
   // per-master mux
   for (genvar gm = 0; gm < N_MST; gm++) begin : g_rsp

      logic own_here;
      logic fin_here;

      // this master owns its target slave
      assign own_here = arb_reg.own_vld[m_tgt[gm]] && (arb_reg.own_idx[m_tgt[gm]] == MIW'(gm));

      // the target slave has just finished for this master
      assign fin_here = own_here && s_done[m_tgt[gm]];

      // answer assembly
      always_comb begin
         m_rsp[gm].rdata = '0;
         m_rsp[gm].err = 1'b0;
         m_rsp[gm].waitreq = 1'b0;
         if (m_active[gm]) begin
            if (!m_mapped[gm]) begin
               // unmapped address ends at once with an error flag
               m_rsp[gm].err = 1'b1;
            end else begin
               m_rsp[gm].waitreq = !fin_here;
               if (fin_here && m_req[gm].rd) begin
                  m_rsp[gm].rdata = s_rdata[m_tgt[gm]];
               end
            end
         end
      end

   end

   // ----------------------------------------------------------------
   // optional slave stall handling
   // ----------------------------------------------------------------
   // optional stall adapted
   // a slave without a stall output sets use_wreq low in its
   // configuration; its stall input is then ignored by the
   // sequencer and only the fixed wait count shapes the strobe

endmodule // cia_fabric

// ---- verification/cia_slv_model.sv ----
// memory-mapped slave model with optional stall
`timescale 1ns/1ns
module cia_slv_model import cia_pkg::*; (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // fabric side
   input wire cia_sreq_s req,
   output cia_srsp_s rsp,
   // stall cycles at the start of each strobe
   input wire logic [1:0] stall
);
   logic [CIA_DW-1:0] mem [0:15];
   logic [1:0] cnt;
   logic [CIA_DW-1:0] noise;
   // stall first, data only while read strobe is up
   assign rsp.waitreq = (req.rd | req.wr) && cnt < stall;
   assign rsp.rdata = (req.sel && req.rd) ? mem[req.addr[3:0]] : noise;
   // strobe counter, write lands on accepting edge
   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         cnt <= 2'h0;
         noise <= 32'h5a5a_a5a5;
      end else begin
         noise <= ~noise; // idle data toggles
         cnt <= (req.rd | req.wr) ? ((cnt == 2'h3) ? cnt : cnt + 2'h1) : 2'h0;
         if (req.sel && req.wr && !rsp.waitreq) begin
            mem[req.addr[3:0]] <= req.wdata;
         end
      end
   end
endmodule // cia_slv_model

// ---- verification/cia_fabric_chk.sv ----
// port assertions of the interconnect fabric
`timescale 1ns/1ns
module cia_fabric_chk import cia_pkg::*; #(
   parameter int N_MST = 2,
   parameter int N_SLV = 2
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // master and slave ports
   input wire cia_mreq_s [N_MST-1:0] m_req,
   input wire cia_mrsp_s [N_MST-1:0] m_rsp,
   input wire cia_sreq_s [N_SLV-1:0] s_req,
   input wire cia_srsp_s [N_SLV-1:0] s_rsp
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   // window hits of the default map
   wire m0_s0 = m_req[0].addr[31:16] == 16'h0;
   wire m0_s1 = m_req[0].addr[31:12] == 20'h00010;
   wire m1_s1 = m_req[1].addr[31:12] == 20'h00010;
   wire want_s1 = (m0_s1 && (m_req[0].rd || m_req[0].wr)) || (m1_s1 && (m_req[1].rd || m_req[1].wr));
   // slow slave phases
   sequence s1_setup;
      (!s_req[1].rd && !s_req[1].wr) [*2] ##1 (s_req[1].rd || s_req[1].wr);
   endsequence
   sequence s1_strobe;
      s_req[1].wr [*3];
   endsequence
   chk_sel_cause: assert property ($rose(s_req[1].sel) |-> $past(want_s1))
      else $error("slave select without request");
   chk_addr_word: assert property ((s_req[1].sel |-> s_req[1].addr[31:10] == 22'h0)
      and (s_req[0].sel |-> s_req[0].addr[31:14] == 18'h0))
      else $error("slave offset too wide");
   chk_unsel_quiet: assert property (!s_req[0].sel |-> s_req[0].addr == '0 && !s_req[0].rd && !s_req[0].wr)
      else $error("idle slave port not quiet");
   chk_zero_strobe: assert property ($rose(s_req[0].rd) |=> !s_req[0].rd && s_req[0].sel)
      else $error("fast slave strobe length");
   chk_setup_first: assert property ($rose(s_req[1].sel) |-> s1_setup)
      else $error("setup cycle missing");
   chk_strobe_len: assert property ($rose(s_req[1].wr) |-> s1_strobe)
      else $error("slow strobe too short");
   chk_stall_hold: assert property ((s_req[1].rd || s_req[1].wr) && s_rsp[1].waitreq
      |=> $stable({s_req[1].rd, s_req[1].wr}) && (s_req[1].rd || s_req[1].wr))
      else $error("strobe ended under stall");
   chk_hold_sel: assert property ($fell(s_req[1].wr) |-> s_req[1].sel [*2])
      else $error("hold cycle missing");
   chk_err_now: assert property (m_req[0].rd && !m0_s0 && !m0_s1 |-> m_rsp[0].err && !m_rsp[0].waitreq)
      else $error("unmapped access not refused");
   chk_read_route: assert property (m_req[0].rd && m0_s0 && !m_rsp[0].waitreq
      |-> $past(s_req[0].rd) && m_rsp[0].rdata == $past(s_rsp[0].rdata))
      else $error("read data misrouted");
   chk_wdata_route: assert property (s_req[1].wr
      |-> s_req[1].wdata == m_req[0].wdata || s_req[1].wdata == m_req[1].wdata)
      else $error("write data misrouted");
endmodule // cia_fabric_chk
bind cia_fabric cia_fabric_chk #(.N_MST(N_MST), .N_SLV(N_SLV)) chk_u (.clk_sys(clk_sys), .rst_b(rst_b),
   .m_req(m_req), .m_rsp(m_rsp), .s_req(s_req), .s_rsp(s_rsp));

// ---- verification/cia_fabric_test.sv ----
// self-checking bench of the interconnect fabric
`timescale 1ns/1ns
module cia_fabric_test import cia_pkg::*;;
   logic clk_sys = 1'b0;
   logic rst_b = 1'b0;
   cia_mreq_s [1:0] m_req = '0;
   cia_mrsp_s [1:0] m_rsp;
   cia_sreq_s [1:0] s_req;
   cia_srsp_s [1:0] s_rsp;
   logic [1:0] stall = 2'h0;
   logic [31:0] q_r [2];
   logic e_r [2];
   int n_r [2];
   int failures = 0;
   int checked = 0;
   // free running clock
   always #5 clk_sys = ~clk_sys;
   cia_fabric dut_u (.clk_sys(clk_sys), .rst_b(rst_b), .m_req(m_req), .m_rsp(m_rsp), .s_req(s_req),
      .s_rsp(s_rsp));
   cia_slv_model slv0_u (.clk_sys(clk_sys), .rst_b(rst_b), .req(s_req[0]), .rsp(s_rsp[0]), .stall(2'h0));
   cia_slv_model slv1_u (.clk_sys(clk_sys), .rst_b(rst_b), .req(s_req[1]), .rsp(s_rsp[1]), .stall(stall));
   // compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // one transfer of master m; n is the cycle where the stall drops
   task automatic xfer(input int m, input logic [31:0] a, input logic w, input logic [31:0] d);
      @(negedge clk_sys);
      m_req[m] = '{addr: a, rd: !w, wr: w, wdata: d, ben: 4'hf};
      n_r[m] = 0;
      #1;
      while (m_rsp[m].waitreq !== 1'b0 && n_r[m] < 40) begin
         @(negedge clk_sys);
         n_r[m]++;
      end
      q_r[m] = m_rsp[m].rdata;
      e_r[m] = m_rsp[m].err;
      // drop request after the done edge, spoiled bus
      @(negedge clk_sys);
      m_req[m] = '{addr: ~a, wdata: ~d, default: '0};
   endtask
   // zero-wait slave from both masters
   task automatic t_plain();
      xfer(0, 32'h0000_0004, 1'b1, 32'h1234_5678);
      chk(32'(n_r[0]), 32'h3);
      xfer(1, 32'h0000_0008, 1'b1, 32'h9abc_def0);
      xfer(0, 32'h0000_0004, 1'b0, 32'h0);
      chk(q_r[0], 32'h1234_5678);
      xfer(1, 32'h0000_0008, 1'b0, 32'h0);
      chk(q_r[1], 32'h9abc_def0);
      $display("test plain done");
   endtask
   // slow slave with setup, wait, hold and stall
   task automatic t_slow();
      stall = 2'h0;
      xfer(0, 32'h0001_0004, 1'b1, 32'h0bad_cafe);
      chk(32'(n_r[0]), 32'h7);
      stall = 2'h3;
      xfer(1, 32'h0001_0004, 1'b0, 32'h0);
      chk(32'(n_r[1]), 32'h8);
      chk(q_r[1], 32'h0bad_cafe);
      stall = 2'h0;
      $display("test slow done");
   endtask
   // access outside every window
   task automatic t_unmapped();
      xfer(0, 32'h2000_0000, 1'b0, 32'h0);
      chk(32'(n_r[0]), 32'h0);
      chk(32'(e_r[0]), 32'h1);
      chk(q_r[0], 32'h0);
      $display("test unmapped done");
   endtask
   // two pairs at once
   task automatic t_pair();
      fork
         xfer(0, 32'h0000_0004, 1'b0, 32'h0);
         xfer(1, 32'h0001_0004, 1'b0, 32'h0);
      join
      chk(32'(n_r[0]), 32'h3);
      chk(32'(n_r[1]), 32'h7);
      chk(q_r[0], 32'h1234_5678);
      chk(q_r[1], 32'h0bad_cafe);
      $display("test pair done");
   endtask
   // both masters on the slow slave, master0 next by round robin
   task automatic t_contend();
      fork
         xfer(0, 32'h0001_0008, 1'b1, 32'h7777_1111);
         xfer(1, 32'h0001_0004, 1'b0, 32'h0);
      join
      chk(32'(n_r[0]), 32'h7);
      chk(32'(n_r[1]), 32'hf);
      chk(q_r[1], 32'h0bad_cafe);
      $display("test contend done");
   endtask
   // verdict and end of run
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // reset then the tests
   initial begin
      repeat (10) @(posedge clk_sys);
      @(negedge clk_sys);
      rst_b = 1'b1;
      t_plain();
      t_slow();
      t_unmapped();
      t_pair();
      t_contend();
      tally_and_finish();
   end
   // hang guard, about five times the expected run
   initial begin
      #4000;
      failures++;
      tally_and_finish();
   end
endmodule // cia_fabric_test
